//--- verilog/ttx_exception_unit.sv
// Trace, breakpoint and system exception sequencing unit
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "ttx_cfg.svh"

module ttx_exception_unit
    import ttx_pkg::*;
(
    input  wire logic                     core_clk,
    input  wire logic                     rstn,
    input  wire logic [`TTX_ADDR_W-1:0]   regAddr,
    input  wire logic [31:0]              regWdata,
    input  wire logic                     regWr,
    input  wire logic                     regRd,
    output logic      [31:0]              regRdata,
    input  wire ttxEvent_s                ev,
    input  wire ttxFork_s                 fork_i,
    input  wire ttxRing_t                 curRing,
    input  wire ttxWord_t                 nextPc,
    input  wire ttxWord_t                 sysVector,
    input  wire ttxWord_t                 sysCause,
    input  wire logic [1:0]               ring0SpLow,
    input  wire logic                     page0Resident,
    input  wire logic                     framePop,
    input  wire logic                     poppedTtc,
    output ttxTrap_s                      trap,
    output logic                          serialExec,
    output logic                          orderedStore
);

    // ----------------------------------------
    // Cause word assembly
    // ----------------------------------------
    function automatic ttxWord_t causeWord(input logic [7:0] cls, input logic [7:0] qual);
        causeWord = {qual, cls, 16'h0000}; // RULE21
    endfunction

    logic [3:0] ctrl_r;
    ttxWord_t   cause_r;
    ttxWord_t   trapPc_r;
    logic [3:0] saved_r;
    ttxTrap_s   trap_r;
    ttxTrap_s   trap_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    wire cpuTtc = ctrl_r[`TTX_BIT_TTC];
    wire cpuTit = ctrl_r[`TTX_BIT_TIT];

    // ----------------------------------------
    // Fork and concurrency decode
    // ----------------------------------------
    wire takeable  = fork_i.posted & fork_i.rcvOk & fork_i.maskAlloc & ~fork_i.halted; // RULE6
    wire idleTake  = ev.idleExec & takeable;
    wire wfLastTk  = ev.wforkExec & ev.lastThread & takeable;
    wire forkTaken = ev.forkPickup | idleTake | wfLastTk;
    wire conc0     = forkTaken & fork_i.pswTtc; // RULE1 RULE2 RULE22
    wire joinOther = ev.joinExec & ~ev.lastThread;
    wire wfOther   = ev.wforkExec & ~ev.lastThread;
    wire idleEmpty = ev.idleExec & ~takeable;
    wire conc1     = joinOther & cpuTtc; // RULE3
    wire conc2     = wfOther & cpuTtc; // RULE4
    wire conc3     = idleEmpty & cpuTtc; // RULE5
    wire initTrap  = forkTaken & fork_i.pswTit; // RULE9 RULE11
    wire goIdle    = (joinOther | wfOther | idleEmpty) & ~cpuTtc;

    // ----------------------------------------
    // System exception decode, no enable gates
    // ----------------------------------------
    wire sysAny    = ev.sysReq | ev.zeroOpcode | ev.procBkpt; // RULE16
    wire ring0Bad  = (ring0SpLow != 2'h0) | ~page0Resident;
    wire machErr   = sysAny & ring0Bad; // RULE18

    ttxKind_e kind;
    assign kind = machErr        ? KIND_MACH  :
                  ev.sysReq      ? KIND_SYS   :
                  ev.zeroOpcode  ? KIND_ZERO  :
                  ev.procBkpt    ? KIND_PBKPT :
                  ev.bkpt        ? KIND_BKPT  :
                  conc0          ? KIND_CONC0 :
                  conc1          ? KIND_CONC1 :
                  conc2          ? KIND_CONC2 :
                  conc3          ? KIND_CONC3 :
                  initTrap       ? KIND_INIT  :
                  goIdle         ? KIND_IDLE  : KIND_NONE;

    // ----------------------------------------
    // Trap frame selection
    // ----------------------------------------
    always_comb begin
        trap_nxt           = '0;
        trap_nxt.valid     = 1'b1;
        trap_nxt.ring      = curRing;
        trap_nxt.frameLen  = `TTX_FRL_EXT;
        trap_nxt.pc        = nextPc;
        trap_nxt.vector    = `TTX_VEC_TRACE;
        unique case (kind)
            // Quiet frame when nothing is taken, so stale fields never leak out
            KIND_NONE: begin
                trap_nxt = '0;
            end
            KIND_IDLE: begin
                trap_nxt           = '0;
                trap_nxt.enterIdle = 1'b1;
            end
            KIND_MACH: begin
                trap_nxt.machine   = 1'b1; // RULE18
                trap_nxt.crossRing = 1'b1;
                trap_nxt.ring      = `TTX_RING0;
                trap_nxt.vector    = `TTX_VEC_MACHINE;
            end
            KIND_SYS: begin
                trap_nxt.crossRing = 1'b1; // RULE17
                trap_nxt.ring      = `TTX_RING0;
                trap_nxt.frameLen  = ev.sysCtx ? `TTX_FRL_CTX : `TTX_FRL_EXT; // RULE17
                trap_nxt.global    = ev.sysGlobal; // RULE19
                trap_nxt.vector    = sysVector;
                trap_nxt.cause     = sysCause;
            end
            KIND_ZERO: begin
                trap_nxt.crossRing = 1'b1; // RULE20
                trap_nxt.ring      = `TTX_RING0;
                trap_nxt.vector    = `TTX_VEC_ERREXIT; // RULE20
            end
            KIND_PBKPT: begin
                trap_nxt.crossRing = 1'b1; // RULE15
                trap_nxt.ring      = `TTX_RING0;
                trap_nxt.vector    = `TTX_VEC_PBKPT;
            end
            KIND_BKPT: begin
                trap_nxt.vector = `TTX_VEC_BKPT; // RULE14
            end
            KIND_CONC0: begin
                trap_nxt.pc    = fork_i.pc; // RULE1
                trap_nxt.cause = causeWord(`TTX_CLASS_CONC, `TTX_QUAL_CREATE); // RULE2
            end
            KIND_CONC1: begin
                trap_nxt.cause = causeWord(`TTX_CLASS_CONC, `TTX_QUAL_JOIN); // RULE3
            end
            KIND_CONC2: begin
                trap_nxt.cause = causeWord(`TTX_CLASS_CONC, `TTX_QUAL_WFORK); // RULE4
            end
            KIND_CONC3: begin
                trap_nxt.cause = causeWord(`TTX_CLASS_CONC, `TTX_QUAL_IDLE); // RULE5
            end
            KIND_INIT: begin
                trap_nxt.pc    = fork_i.pc; // RULE9
                trap_nxt.cause = causeWord(`TTX_CLASS_INIT, 8'h00); // RULE21
            end
            default: begin
                trap_nxt.valid = 1'b0;
            end
        endcase
    end
    // Init trap keeps curRing and no crossing RULE10

    // ----------------------------------------
    // Register read decode
    // ----------------------------------------
    wire selCtrl  = regAddr == `TTX_OFF_CTRL;
    wire selCause = regAddr == `TTX_OFF_CAUSE;
    wire selPc    = regAddr == `TTX_OFF_TRAPPC;
    wire selSaved = regAddr == `TTX_OFF_SAVED;
    assign rdata_nxt = ~regRd   ? 32'h0000_0000 :
                       selCtrl  ? {28'h0000000, ctrl_r} :
                       selCause ? cause_r :
                       selPc    ? trapPc_r :
                       selSaved ? {28'h0000000, saved_r} : 32'h0000_0000;

    wire trapTaken = trap_nxt.valid;

    // Status word: frame pop reload beats a software write in the same cycle
    logic [3:0] ctrl_nxt;
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (regWr && selCtrl) begin
            ctrl_nxt = regWdata[3:0]; // RULE12 RULE13
        end
        if (framePop) begin
            ctrl_nxt[`TTX_BIT_TTC] = poppedTtc; // RULE7
        end
    end

    // ----------------------------------------
    // State registers
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ctrl_r   <= `TTX_CTRL_RST;
            cause_r  <= '0;
            trapPc_r <= '0;
            saved_r  <= '0;
            trap_r   <= '0;
            rdata_r  <= '0;
        end else begin
            ctrl_r  <= ctrl_nxt;
            trap_r  <= trap_nxt;
            rdata_r <= rdata_nxt;
            if (trapTaken) begin
                cause_r  <= trap_nxt.cause;
                trapPc_r <= trap_nxt.pc;
                saved_r  <= ctrl_r;
            end
        end
    end

    assign trap         = trap_r;
    assign regRdata     = rdata_r;
    assign serialExec   = ctrl_r[`TTX_BIT_SERIAL]; // RULE12
    assign orderedStore = ctrl_r[`TTX_BIT_ORDERED]; // RULE13

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    AST_CONC_PICKUP: assert property ( // RULE2
        ev.forkPickup && fork_i.pswTtc && !sysAny && !ev.bkpt |=>
        trap.valid && trap.cause == 32'h0004_0000 && trap.pc == $past(fork_i.pc))
        else $error("fork pickup trace trap wrong");
    AST_JOIN_TRAP: assert property ( // RULE3
        ev.joinExec && !ev.lastThread && cpuTtc && !sysAny && !ev.bkpt && !forkTaken |=>
        trap.valid && trap.cause == 32'h0104_0000 && !trap.enterIdle)
        else $error("join trace trap wrong");
    AST_WFORK_TRAP: assert property ( // RULE4
        ev.wforkExec && !ev.lastThread && cpuTtc && !sysAny && !ev.bkpt && !forkTaken |=>
        trap.valid && trap.cause == 32'h0204_0000)
        else $error("wait-fork trace trap wrong");
    AST_IDLE_EMPTY: assert property ( // RULE5
        ev.idleExec && !fork_i.posted && cpuTtc && !sysAny && !ev.bkpt && !ev.forkPickup
        |=> trap.valid && trap.cause == 32'h0304_0000)
        else $error("idle trace trap wrong");
    AST_HALTED_FORK: assert property ( // RULE6
        ev.idleExec && fork_i.halted && !cpuTtc && !sysAny && !ev.bkpt && !ev.forkPickup
        && !ev.joinExec && !ev.wforkExec |=> trap.enterIdle && !trap.valid)
        else $error("halted fork was taken");
    AST_INIT_RING: assert property ( // RULE10
        ev.forkPickup && fork_i.pswTit && !fork_i.pswTtc && !sysAny && !ev.bkpt |=>
        trap.valid && !trap.crossRing && trap.ring == $past(curRing)
        && trap.cause == 32'h0008_0000)
        else $error("init trap crossed ring");
    AST_BKPT_VEC: assert property ( // RULE14
        ev.bkpt && !sysAny |=> trap.valid && trap.vector == 32'h0000_0050
        && trap.frameLen == 2'h1 && !trap.crossRing)
        else $error("breakpoint vector wrong");
    AST_SYS_RING0: assert property ( // RULE17
        ev.sysReq && !ring0Bad |=> trap.crossRing && trap.ring == 3'h0
        && trap.frameLen == ($past(ev.sysCtx) ? 2'h0 : 2'h1))
        else $error("system exception frame wrong");
    AST_MACHINE: assert property ( // RULE18
        sysAny && (ring0SpLow != 2'h0) |=> trap.machine && trap.valid)
        else $error("machine exception missing");
    AST_ERREXIT: assert property ( // RULE20
        ev.zeroOpcode && !ev.sysReq && !ring0Bad |=> trap.vector == 32'h0000_000c
        && trap.crossRing)
        else $error("error exit vector wrong");
    AST_POP_TTC: assert property ( // RULE7
        framePop ##1 1'b1 |-> ctrl_r[`TTX_BIT_TTC] == $past(poppedTtc))
        else $error("popped status not restored");
    AST_READ_ONE: assert property (
        !regRd |=> regRdata == 32'h0000_0000)
        else $error("read data outside read slot");

    COV_CONC_JOIN: cover property (conc1 ##1 trap.valid);
    COV_INIT_TRAP: cover property (kind == KIND_INIT ##1 trap.valid);
    COV_MACHINE:   cover property (machErr ##1 trap.machine);
    COV_POP:       cover property (framePop && poppedTtc);

endmodule

//--- verilog/ttx_cfg.svh
// Offsets, field positions, reset values and trap codes of the trace exception unit
// Operation
// [RULE1] Concurrency trace uses the fork block status word; trap PC is fork start.
// [RULE2] Code 0400 on fork pickup, idle taking fork, last-thread wait-fork taking fork.
// [RULE3] Non-last join with tracing on traps with 0401, not idle loop.
// [RULE4] Non-last wait-fork with tracing on traps with 0402, not idle loop.
// [RULE5] Idle finding no fork with own trace bit set traps with 0403.
// [RULE6] No fork takeable: none posted, no receive, no allocatable thread, or halted.
// [RULE7] Popping the trace frame restores the saved status word trace bit.
// [RULE8] Handler software joins all threads, then only the last thread returns.
// [RULE9] Fork pickup with init-trap bit set traps first, PC is fork start.
// [RULE10] Init trap is a user trap in the current ring, no ring crossing.
// [RULE11] Init trap works with or without serial execution mode.
// [RULE12] Serial-execution bit disables all overlap; software sets or clears it freely.
// [RULE13] Ordered-store bit forces stores in program order; freely changeable.
// [RULE14] Breakpoint pushes extended block, jumps via pointer at 0000 0050 current ring.
// [RULE15] Process breakpoint is a system exception crossing to ring 0.
// [RULE16] System exceptions are never masked by any enable bit.
// [RULE17] System exception crosses to ring 0, pushes extended (01) or context (00) block.
// [RULE18] Misaligned ring 0 stack or non-resident ring 0 page 0 gives machine exception.
// [RULE19] Only process deadlock and process trap are global system exceptions.
// [RULE20] All-zero opcode raises error exit via pointer at 0000 000C of ring 0.
// [RULE21] Trace class goes to cause byte 2, qualifier to byte 3; classes 04, 08.
// [RULE22] With tracing set, a new thread accepting fork or spawn traps first.
`ifndef TTX_CFG_SVH
`define TTX_CFG_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define TTX_ADDR_W        8
`define TTX_OFF_CTRL      8'h00
`define TTX_OFF_CAUSE     8'h04
`define TTX_OFF_TRAPPC    8'h08
`define TTX_OFF_SAVED     8'h0c
`define TTX_BIT_SERIAL    0
`define TTX_BIT_ORDERED   1
`define TTX_BIT_TTC       2
`define TTX_BIT_TIT       3
`define TTX_CTRL_RST      4'h0

// ----------------------------------------
// Handler pointers in page 0
// ----------------------------------------
`define TTX_VEC_TRACE     32'h0000_0040
`define TTX_VEC_BKPT      32'h0000_0050
`define TTX_VEC_ERREXIT   32'h0000_000c
`define TTX_VEC_PBKPT     32'h0000_0014
`define TTX_VEC_MACHINE   32'h0000_0008

// ----------------------------------------
// Trap cause codes and frame lengths
// ----------------------------------------
`define TTX_CLASS_CONC    8'h04
`define TTX_CLASS_INIT    8'h08
`define TTX_QUAL_CREATE   8'h00
`define TTX_QUAL_JOIN     8'h01
`define TTX_QUAL_WFORK    8'h02
`define TTX_QUAL_IDLE     8'h03
`define TTX_FRL_EXT       2'h1
`define TTX_FRL_CTX       2'h0
`define TTX_RING0         3'h0

`endif

//--- verilog/ttx_pkg.sv
// Types shared by the trace exception unit
package ttx_pkg;

    typedef logic [2:0]  ttxRing_t;
    typedef logic [31:0] ttxWord_t;

    // Instruction events from the issue stage, one-cycle pulses
    typedef struct packed {
        logic forkPickup;
        logic idleExec;
        logic wforkExec;
        logic joinExec;
        logic lastThread;
        logic bkpt;
        logic procBkpt;
        logic zeroOpcode;
        logic sysReq;
        logic sysCtx;
        logic sysGlobal;
    } ttxEvent_s;

    // Fork block as seen in the fork slot register
    typedef struct packed {
        logic     posted;
        logic     rcvOk;
        logic     maskAlloc;
        logic     halted;
        logic     pswTtc;
        logic     pswTit;
        ttxWord_t pc;
    } ttxFork_s;

    typedef struct packed {
        logic     valid;
        logic     machine;
        logic     crossRing;
        logic     global;
        logic     enterIdle;
        logic [1:0] frameLen;
        ttxRing_t ring;
        ttxWord_t vector;
        ttxWord_t cause;
        ttxWord_t pc;
    } ttxTrap_s;

    typedef enum logic [10:0] {
        KIND_NONE  = 11'h000,
        KIND_MACH  = 11'h001,
        KIND_SYS   = 11'h002,
        KIND_ZERO  = 11'h004,
        KIND_PBKPT = 11'h008,
        KIND_BKPT  = 11'h010,
        KIND_CONC0 = 11'h020,
        KIND_CONC1 = 11'h040,
        KIND_CONC2 = 11'h080,
        KIND_CONC3 = 11'h100,
        KIND_INIT  = 11'h200,
        KIND_IDLE  = 11'h400
    } ttxKind_e;

endpackage

//--- tb/ttx_exception_unit_test.sv
// Self-checking testbench for the trace exception unit
`timescale 1ns/1ps
`include "ttx_cfg.svh"

module ttx_exception_unit_test
    import ttx_pkg::*;
;
    // ----------------------------------------
    // Stimulus and observation signals
    // ----------------------------------------
    localparam ttxWord_t FORK_PC = 32'h0000_2000;
    localparam ttxWord_t NEXT_PC = 32'h0000_1004;
    localparam ttxRing_t USR     = 3'h3;

    logic        core_clk;
    logic        rstn;
    logic [7:0]  regAddr;
    logic [31:0] regWdata;
    logic        regWr;
    logic        regRd;
    logic [31:0] regRdata;
    ttxEvent_s   ev;
    ttxFork_s    fork_i;
    ttxRing_t    curRing;
    ttxWord_t    nextPc;
    ttxWord_t    sysVector;
    ttxWord_t    sysCause;
    logic [1:0]  ring0SpLow;
    logic        page0Resident;
    logic        framePop;
    logic        poppedTtc;
    ttxTrap_s    trap;
    logic        serialExec;
    logic        orderedStore;
    int          nErrors;
    int          nChecks;

    ttx_exception_unit uut (
        .core_clk(core_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .ev(ev), .fork_i(fork_i),
        .curRing(curRing), .nextPc(nextPc), .sysVector(sysVector), .sysCause(sysCause),
        .ring0SpLow(ring0SpLow), .page0Resident(page0Resident), .framePop(framePop),
        .poppedTtc(poppedTtc), .trap(trap), .serialExec(serialExec),
        .orderedStore(orderedStore)
    );

    always #12.5 core_clk = ~core_clk;

    // ----------------------------------------
    // Shared helpers
    // ----------------------------------------
    task automatic check(input logic [127:0] got, input logic [127:0] exp);
        nChecks++;
        if (got !== exp) begin
            nErrors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic ttxTrap_s mk(input logic c, input logic [1:0] return_frame_length, input ttxRing_t r,
                                    input ttxWord_t vec, input ttxWord_t cs, input ttxWord_t pc);
        mk = '0;
        mk.valid = 1'b1;
        mk.crossRing = c;
        mk.frameLen = return_frame_length;
        mk.ring = r;
        mk.vector = vec;
        mk.cause = cs;
        mk.pc = pc;
    endfunction

    function automatic ttxTrap_s conc(input logic [7:0] qual, input ttxWord_t pc);
        conc = mk(1'b0, `TTX_FRL_EXT, USR, `TTX_VEC_TRACE, {qual, `TTX_CLASS_CONC, 16'h0000}, pc);
    endfunction

    function automatic ttxFork_s goodFork();
        goodFork = '{posted: 1'b1, rcvOk: 1'b1, maskAlloc: 1'b1, halted: 1'b0,
                     pswTtc: 1'b0, pswTit: 1'b0, pc: FORK_PC};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1 check(128'(regRdata), 128'(exp));
    endtask

    // Event held one cycle; the trap is registered, so it is seen just after the next edge
    task automatic pulse(input ttxEvent_s e, input ttxFork_s f);
        @(posedge core_clk);
        ev <= e;
        fork_i <= f;
        @(posedge core_clk);
        ev <= '0;
        #1;
    endtask

    task automatic fire(input ttxEvent_s e, input ttxFork_s f, input ttxTrap_s exp);
        pulse(e, f);
        check(128'(trap), 128'(exp));
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reg();
        check(128'({serialExec, orderedStore, trap}), 128'(0));
        rd(`TTX_OFF_CTRL, 32'h0);
        wr(`TTX_OFF_CTRL, 32'h0000_0003);
        check(128'({serialExec, orderedStore}), 128'(3));
        wr(`TTX_OFF_CTRL, 32'h0000_0001);
        check(128'({serialExec, orderedStore}), 128'(2));
        wr(`TTX_OFF_CAUSE, 32'hffff_ffff);
        rd(`TTX_OFF_CAUSE, 32'h0);
        rd(8'h10, 32'h0);
        @(posedge core_clk);
        #1 check(128'(regRdata), 128'(0));
    endtask

    task automatic t_conc();
        ttxEvent_s e;
        ttxFork_s  f;
        ttxTrap_s  idleX;
        idleX = '0;
        idleX.enterIdle = 1'b1;
        wr(`TTX_OFF_CTRL, 32'h0000_0004);
        e = '0;
        e.joinExec = 1'b1;
        fire(e, goodFork(), conc(`TTX_QUAL_JOIN, NEXT_PC));
        e.lastThread = 1'b1;
        fire(e, goodFork(), '0);
        e = '0;
        e.wforkExec = 1'b1;
        fire(e, goodFork(), conc(`TTX_QUAL_WFORK, NEXT_PC));
        // Fork with trace bit set but untakeable must not give the create code
        for (int i = 0; i < 4; i++) begin
            f = goodFork();
            f.pswTtc = 1'b1;
            f.posted = (i != 0);
            f.rcvOk = (i != 1);
            f.maskAlloc = (i != 2);
            f.halted = (i == 3);
            e = '0;
            e.idleExec = 1'b1;
            fire(e, f, conc(`TTX_QUAL_IDLE, NEXT_PC));
        end
        rd(`TTX_OFF_CAUSE, 32'h0304_0000);
        wr(`TTX_OFF_CTRL, 32'h0000_0000);
        f = goodFork();
        f.pswTtc = 1'b1;
        fire(e, f, conc(`TTX_QUAL_CREATE, FORK_PC));
        e = '0;
        e.wforkExec = 1'b1;
        e.lastThread = 1'b1;
        fire(e, f, conc(`TTX_QUAL_CREATE, FORK_PC));
        e = '0;
        e.forkPickup = 1'b1;
        fire(e, f, conc(`TTX_QUAL_CREATE, FORK_PC));
        rd(`TTX_OFF_TRAPPC, FORK_PC);
        e.joinExec = 1'b1;
        e.forkPickup = 1'b0;
        fire(e, goodFork(), idleX);
    endtask

    task automatic t_init();
        ttxEvent_s e;
        ttxFork_s  f;
        e = '0;
        e.forkPickup = 1'b1;
        f = goodFork();
        f.pswTit = 1'b1;
        for (int s = 0; s < 2; s++) begin
            wr(`TTX_OFF_CTRL, 32'(s));
            fire(e, f, mk(1'b0, `TTX_FRL_EXT, USR, `TTX_VEC_TRACE,
                          {8'h00, `TTX_CLASS_INIT, 16'h0000}, FORK_PC));
        end
        f.pswTtc = 1'b1;
        fire(e, f, conc(`TTX_QUAL_CREATE, FORK_PC));
    endtask

    task automatic t_sys();
        ttxEvent_s e;
        ttxTrap_s  x;
        wr(`TTX_OFF_CTRL, 32'h0);
        e = '0;
        e.bkpt = 1'b1;
        fire(e, goodFork(), mk(1'b0, `TTX_FRL_EXT, USR, `TTX_VEC_BKPT, 32'h0, NEXT_PC));
        e = '0;
        e.procBkpt = 1'b1;
        fire(e, goodFork(), mk(1'b1, `TTX_FRL_EXT, `TTX_RING0, `TTX_VEC_PBKPT, 32'h0,
                               NEXT_PC));
        e = '0;
        e.zeroOpcode = 1'b1;
        fire(e, goodFork(), mk(1'b1, `TTX_FRL_EXT, `TTX_RING0, `TTX_VEC_ERREXIT, 32'h0,
                               NEXT_PC));
        e.bkpt = 1'b1;
        e.zeroOpcode = 1'b0;
        e.sysReq = 1'b1;
        e.sysCtx = 1'b1;
        e.sysGlobal = 1'b1;
        x = mk(1'b1, `TTX_FRL_CTX, `TTX_RING0, 32'h0000_0030, 32'h0003_0000, NEXT_PC);
        x.global = 1'b1;
        fire(e, goodFork(), x);
        e.sysCtx = 1'b0;
        e.sysGlobal = 1'b0;
        x.global = 1'b0;
        x.frameLen = `TTX_FRL_EXT;
        fire(e, goodFork(), x);
        for (int i = 0; i < 2; i++) begin
            @(posedge core_clk);
            ring0SpLow <= (i == 0) ? 2'h2 : 2'h0;
            page0Resident <= (i == 1) ? 1'b0 : 1'b1;
            pulse(e, goodFork());
            check(128'({trap.valid, trap.machine, trap.vector}),
                  128'({2'b11, `TTX_VEC_MACHINE}));
        end
        page0Resident <= 1'b1;
    endtask

    task automatic t_pop();
        wr(`TTX_OFF_CTRL, 32'h0);
        @(posedge core_clk);
        // Frame pop reloads the status word trace bit from the popped frame
        framePop <= 1'b1;
        poppedTtc <= 1'b1;
        @(posedge core_clk);
        framePop <= 1'b0;
        poppedTtc <= 1'b0;
        rd(`TTX_OFF_CTRL, 32'h0000_0004);
    endtask

    // ----------------------------------------
    // Verdict and run control
    // ----------------------------------------
    task automatic final_report();
        if (nErrors == 0 && nChecks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        rstn = 1'b0;
        {regAddr, regWdata, regWr, regRd} = '0;
        ev = '0;
        fork_i = goodFork();
        curRing = USR;
        nextPc = NEXT_PC;
        sysVector = 32'h0000_0030;
        sysCause = 32'h0003_0000;
        ring0SpLow = 2'h0;
        page0Resident = 1'b1;
        {framePop, poppedTtc} = 2'b00;
        nErrors = 0;
        nChecks = 0;
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        #1;
        t_reg();
        t_conc();
        t_init();
        t_sys();
        t_pop();
        final_report();
    end

    // Whole run is under a hundred cycles; a generous bound still stops a hang
    initial begin
        repeat (8000) @(posedge core_clk);
        nErrors++;
        final_report();
    end

endmodule
